//--- hdl/cpu_register_bank.sv
// Dedicated CPU registers, status word, flag update and address generation
// Overview of operation
// - Memory addresses span a flat 64 Kbyte space with banks and vectors inside.
// - A 16-bit program counter holds the current instruction location.
// - 16-bit accumulator takes results; byte operations touch only its low byte.
// - 16-bit second operand pairs with accumulator; byte operations use its low byte.
// - Index pointer, extra pointer and stack top are further 16-bit registers.
// - Status word: bank and window selectors high byte, flags low byte.
// - Register address is zeros, a one, bank selector, then low opcode bits.
// - Direct addresses 0000-007F always reach themselves.
// - Direct 0080-00FF move by window selector; zero keeps them in place.
// - Half carry marks carry or borrow between bits 3 and 4.
// - Interrupt enable flag permits requests when one, cleared by reset.
// - Only requests of higher priority than current level are admitted.
// - Negative flag copies the result's most significant bit.
// - Zero flag is set exactly when the result is zero.
// - Overflow flag marks two's complement overflow of the result.
// - Carry marks carry or borrow out of the top bit; shifts load shifted-out bit.
// - General registers are bytes in memory, eight per bank, 32 banks.
// - Low three opcode bits choose one of eight registers in the bank.
//
// Implementation choices: the register addresses and strobed register access.
`include "cpu_regs_map.svh"
module cpu_register_bank (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic alu_go_i,
  input wire cpu_regs_pkg::alu_op_t alu_op_i,
  input wire logic alu_byte_i,
  input wire logic pc_inc_i,
  input wire logic pc_load_i,
  input wire logic [15:0] pc_value_i,
  input wire logic sp_push_i,
  input wire logic sp_pop_i,
  input wire cpu_regs_pkg::addr_sel_t mem_sel_i,
  input wire logic [2:0] opcode_lo_i,
  input wire logic [7:0] direct_i,
  input wire logic [7:0] index_disp_i,
  output logic [15:0] mem_addr_o,
  input wire logic irq_req_i,
  input wire logic [1:0] irq_level_i,
  output logic irq_accept_o,
  output logic [15:0] program_counter_o,
  output logic [15:0] program_status_word_o
);
  logic [15:0] program_counter_q;
  logic [15:0] accumulator_q;
  logic [15:0] second_operand_q;
  logic [15:0] index_pointer_q;
  logic [15:0] extra_pointer_q;
  logic [15:0] stack_top_q;
  logic [15:0] program_status_word;
  logic [4:0] bank_select_q;
  logic [2:0] direct_window_sel_q;
  logic half_carry_q;
  logic irq_enable_q;
  logic [1:0] irq_level_q;
  logic negative_q;
  logic zero_q;
  logic overflow_q;
  logic carry_q;
  logic [15:0] reg_rdata_q;
  logic [15:0] mem_addr_q;
  logic irq_accept_q;

  logic [15:0] mem_addr_d;
  logic [15:0] reg_rdata_d;
  logic [15:0] alu_result;
  cpu_regs_pkg::arith_flags_t alu_flags_new;
  logic [15:0] gpr_addr;
  logic [15:0] direct_addr;
  logic [4:0] bank_select;
  logic [2:0] direct_window_sel;
  logic [7:0] condition_flags;
  logic irq_enable;
  logic [1:0] irq_level;
  logic irq_admit;
  logic status_wr;

  function automatic logic bus_hit(input logic [3:0] addr, input logic [3:0] ofs, input logic wr);
    bus_hit = wr && (addr == ofs);
  endfunction

  // Smaller level numbers are more urgent, so a request must carry a smaller number
  function automatic logic level_beats(input logic [1:0] req_level, input logic [1:0] cur_level);
    level_beats = req_level < cur_level;
  endfunction

  // Displacement is signed, so negative offsets reach below the index pointer
  function automatic logic [15:0] indexed(input logic [15:0] base, input logic [7:0] disp);
    indexed = base + {{8{disp[7]}}, disp};
  endfunction

  // Status word is wired from its field registers: selectors high, flags low
  assign condition_flags = {half_carry_q, irq_enable_q, irq_level_q, negative_q, zero_q, overflow_q, carry_q};
  assign program_status_word = {bank_select_q, direct_window_sel_q, condition_flags};
  assign bank_select = bank_select_q;
  assign direct_window_sel = direct_window_sel_q;
  assign irq_enable = irq_enable_q;
  assign irq_level = irq_level_q;
  // One decode of the status word write serves every field register
  assign status_wr = bus_hit(reg_addr_i, `OFS_PROGRAM_STATUS, reg_wr_i);

  alu_flags u_alu_flags (
    .a_i(accumulator_q),
    .t_i(second_operand_q),
    .op_i(alu_op_i),
    .byte_i(alu_byte_i),
    .carry_i(condition_flags[`FLAG_CARRY]),
    .half_i(condition_flags[`FLAG_HALF_CARRY]),
    .result_o(alu_result),
    .flags_o(alu_flags_new)
  );

  addr_gen u_addr_gen (
    .bank_select_i(bank_select),
    .direct_window_sel_i(direct_window_sel),
    .opcode_lo_i(opcode_lo_i),
    .direct_i(direct_i),
    .gpr_addr_o(gpr_addr),
    .direct_addr_o(direct_addr)
  );

  // Program counter: a bus write beats a jump load, which beats the step
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      program_counter_q <= `RST_PROGRAM_COUNTER;
    end else if (bus_hit(reg_addr_i, `OFS_PROGRAM_COUNTER, reg_wr_i)) begin
      program_counter_q <= reg_wdata_i;
    end else if (pc_load_i) begin
      program_counter_q <= pc_value_i;
    end else if (pc_inc_i) begin
      program_counter_q <= program_counter_q + `PC_STEP;
    end
  end

  // Accumulator: byte results keep the high byte inside alu_result
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accumulator_q <= `RST_DATA_REG;
    end else if (bus_hit(reg_addr_i, `OFS_ACCUMULATOR, reg_wr_i)) begin
      accumulator_q <= reg_wdata_i;
    end else if (alu_go_i) begin
      accumulator_q <= alu_result;
    end
  end

  // Second operand is written only by the bus; the arithmetic unit and the read mux read it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      second_operand_q <= `RST_DATA_REG;
    end else if (bus_hit(reg_addr_i, `OFS_SECOND_OPERAND, reg_wr_i)) begin
      second_operand_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      index_pointer_q <= `RST_DATA_REG;
    end else if (bus_hit(reg_addr_i, `OFS_INDEX_POINTER, reg_wr_i)) begin
      index_pointer_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      extra_pointer_q <= `RST_DATA_REG;
    end else if (bus_hit(reg_addr_i, `OFS_EXTRA_POINTER, reg_wr_i)) begin
      extra_pointer_q <= reg_wdata_i;
    end
  end

  // Stack grows downward one word per push
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stack_top_q <= `RST_DATA_REG;
    end else if (bus_hit(reg_addr_i, `OFS_STACK_TOP, reg_wr_i)) begin
      stack_top_q <= reg_wdata_i;
    end else if (sp_push_i && !sp_pop_i) begin
      stack_top_q <= stack_top_q - `STACK_STEP;
    end else if (sp_pop_i && !sp_push_i) begin
      stack_top_q <= stack_top_q + `STACK_STEP;
    end
  end

  // Bank selector moves only under software control
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_select_q <= `RST_BANK_SELECT;
    end else if (status_wr) begin
      bank_select_q <= reg_wdata_i[`BANK_SELECT_HI:`BANK_SELECT_LO];
    end
  end

  // Window 0 after reset leaves direct addresses where they are
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      direct_window_sel_q <= `RST_DIRECT_WINDOW;
    end else if (status_wr) begin
      direct_window_sel_q <= reg_wdata_i[`DIRECT_WINDOW_HI:`DIRECT_WINDOW_LO];
    end
  end

  // Interrupts stay blocked from reset until software sets the enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_enable_q <= `RST_FLAG;
    end else if (status_wr) begin
      irq_enable_q <= reg_wdata_i[`FLAG_IRQ_ENABLE];
    end
  end

  // Level 0 after reset admits nothing until software relaxes it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_level_q <= `RST_IRQ_LEVEL;
    end else if (status_wr) begin
      irq_level_q <= {reg_wdata_i[`FLAG_IRQ_LEVEL_HI], reg_wdata_i[`FLAG_IRQ_LEVEL_LO]};
    end
  end

  // Arithmetic flags: a software write beats an update in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half_carry_q <= `RST_FLAG;
    end else if (status_wr) begin
      half_carry_q <= reg_wdata_i[`FLAG_HALF_CARRY];
    end else if (alu_go_i) begin
      half_carry_q <= alu_flags_new.half_carry;
    end
  end

  // Negative follows the top bit of the byte or word result
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      negative_q <= `RST_FLAG;
    end else if (status_wr) begin
      negative_q <= reg_wdata_i[`FLAG_NEGATIVE];
    end else if (alu_go_i) begin
      negative_q <= alu_flags_new.negative;
    end
  end

  // Zero looks only at the width that the operation used
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zero_q <= `RST_FLAG;
    end else if (status_wr) begin
      zero_q <= reg_wdata_i[`FLAG_ZERO];
    end else if (alu_go_i) begin
      zero_q <= alu_flags_new.zero;
    end
  end

  // Logic, shift and move results clear overflow
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_q <= `RST_FLAG;
    end else if (status_wr) begin
      overflow_q <= reg_wdata_i[`FLAG_OVERFLOW];
    end else if (alu_go_i) begin
      overflow_q <= alu_flags_new.overflow;
    end
  end

  // Shifts load the bit shifted out instead of a carry
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      carry_q <= `RST_FLAG;
    end else if (status_wr) begin
      carry_q <= reg_wdata_i[`FLAG_CARRY];
    end else if (alu_go_i) begin
      carry_q <= alu_flags_new.carry;
    end
  end

  // Memory address for the next access, all inside the 64 Kbyte space
  always_comb begin
    case (mem_sel_i)
      cpu_regs_pkg::SEL_FETCH: mem_addr_d = program_counter_q;
      cpu_regs_pkg::SEL_GPR: mem_addr_d = gpr_addr;
      cpu_regs_pkg::SEL_DIRECT: mem_addr_d = direct_addr;
      cpu_regs_pkg::SEL_INDEXED: mem_addr_d = indexed(index_pointer_q, index_disp_i);
      cpu_regs_pkg::SEL_EXTRA: mem_addr_d = extra_pointer_q;
      cpu_regs_pkg::SEL_STACK: mem_addr_d = stack_top_q;
      default: mem_addr_d = program_counter_q;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_addr_q <= 16'h0000;
    end else begin
      mem_addr_q <= mem_addr_d;
    end
  end

  // An equal level waits, so level 3 still admits the three more urgent ones
  assign irq_admit = irq_req_i && irq_enable && level_beats(irq_level_i, irq_level);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_accept_q <= 1'b0;
    end else begin
      irq_accept_q <= irq_admit;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (reg_addr_i)
      `OFS_PROGRAM_COUNTER: reg_rdata_d = program_counter_q;
      `OFS_ACCUMULATOR: reg_rdata_d = accumulator_q;
      `OFS_SECOND_OPERAND: reg_rdata_d = second_operand_q;
      `OFS_INDEX_POINTER: reg_rdata_d = index_pointer_q;
      `OFS_EXTRA_POINTER: reg_rdata_d = extra_pointer_q;
      `OFS_STACK_TOP: reg_rdata_d = stack_top_q;
      `OFS_PROGRAM_STATUS: reg_rdata_d = program_status_word;
      default: reg_rdata_d = 16'h0000;
    endcase
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_q <= reg_rdata_d;
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata_o = reg_rdata_q;
  assign mem_addr_o = mem_addr_q;
  assign irq_accept_o = irq_accept_q;
  assign program_counter_o = program_counter_q;
  assign program_status_word_o = program_status_word;

endmodule // cpu_register_bank

//--- hdl/cpu_regs_map.svh
// Offsets, field positions, reset values and steps of the CPU register bank
`ifndef CPU_REGS_MAP_SVH
`define CPU_REGS_MAP_SVH

`define OFS_PROGRAM_COUNTER 4'h0
`define OFS_ACCUMULATOR 4'h1
`define OFS_SECOND_OPERAND 4'h2
`define OFS_INDEX_POINTER 4'h3
`define OFS_EXTRA_POINTER 4'h4
`define OFS_STACK_TOP 4'h5
`define OFS_PROGRAM_STATUS 4'h6

`define BANK_SELECT_HI 15
`define BANK_SELECT_LO 11
`define DIRECT_WINDOW_HI 10
`define DIRECT_WINDOW_LO 8
`define FLAG_HALF_CARRY 7
`define FLAG_IRQ_ENABLE 6
`define FLAG_IRQ_LEVEL_HI 5
`define FLAG_IRQ_LEVEL_LO 4
`define FLAG_NEGATIVE 3
`define FLAG_ZERO 2
`define FLAG_OVERFLOW 1
`define FLAG_CARRY 0

`define RST_PROGRAM_COUNTER 16'h0000
`define RST_DATA_REG 16'h0000
`define RST_PROGRAM_STATUS 16'h0000
`define RST_BANK_SELECT 5'h00
`define RST_DIRECT_WINDOW 3'h0
`define RST_IRQ_LEVEL 2'h0
`define RST_FLAG 1'h0

`define STACK_STEP 16'h0002
`define PC_STEP 16'h0001
`define GPR_AREA_BIT 8'h01
`define PAGE_ZERO_HI 8'h00

`endif

//--- hdl/cpu_regs_pkg.sv
// Types shared by the CPU register bank and its helpers
package cpu_regs_pkg;

  typedef enum logic [3:0] {
    OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_SHL, OP_SHR, OP_AND, OP_OR, OP_XOR, OP_PASS
  } alu_op_t;

  typedef enum logic [2:0] {
    SEL_FETCH, SEL_GPR, SEL_DIRECT, SEL_INDEXED, SEL_EXTRA, SEL_STACK
  } addr_sel_t;

  typedef struct packed {
    logic half_carry;
    logic negative;
    logic zero;
    logic overflow;
    logic carry;
  } arith_flags_t;

endpackage

//--- hdl/alu_flags.sv
// Arithmetic result and condition flags for byte and word operations
module alu_flags (
  input wire logic [15:0] a_i,
  input wire logic [15:0] t_i,
  input wire cpu_regs_pkg::alu_op_t op_i,
  input wire logic byte_i,
  input wire logic carry_i,
  input wire logic half_i,
  output logic [15:0] result_o,
  output cpu_regs_pkg::arith_flags_t flags_o
);
  logic sub;
  logic cin;
  logic [15:0] b;
  logic [16:0] sum;
  logic [8:0] sum8;
  logic [4:0] nib;
  logic msb_a;
  logic msb_b;
  logic msb_r;

  always_comb begin
    sub = (op_i == cpu_regs_pkg::OP_SUB) || (op_i == cpu_regs_pkg::OP_SBC);
    case (op_i)
      cpu_regs_pkg::OP_ADC: cin = carry_i;
      cpu_regs_pkg::OP_SUB: cin = 1'b1;
      cpu_regs_pkg::OP_SBC: cin = ~carry_i;
      default: cin = 1'b0;
    endcase
    b = sub ? ~t_i : t_i;
    sum = {1'b0, a_i} + {1'b0, b} + {16'h0000, cin};
    sum8 = {1'b0, a_i[7:0]} + {1'b0, b[7:0]} + {8'h00, cin};
    nib = {1'b0, a_i[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    flags_o = '0;
    flags_o.half_carry = half_i;
    flags_o.carry = carry_i;
    case (op_i)
      cpu_regs_pkg::OP_ADD, cpu_regs_pkg::OP_ADC, cpu_regs_pkg::OP_SUB, cpu_regs_pkg::OP_SBC: begin
        result_o = byte_i ? {a_i[15:8], sum8[7:0]} : sum[15:0];
        flags_o.half_carry = nib[4] ^ sub;
        flags_o.carry = (byte_i ? sum8[8] : sum[16]) ^ sub;
      end
      cpu_regs_pkg::OP_SHL: begin
        result_o = byte_i ? {a_i[15:8], a_i[6:0], 1'b0} : {a_i[14:0], 1'b0};
        flags_o.carry = byte_i ? a_i[7] : a_i[15];
      end
      cpu_regs_pkg::OP_SHR: begin
        result_o = byte_i ? {a_i[15:8], 1'b0, a_i[7:1]} : {1'b0, a_i[15:1]};
        flags_o.carry = a_i[0];
      end
      cpu_regs_pkg::OP_AND: result_o = byte_i ? {a_i[15:8], a_i[7:0] & t_i[7:0]} : a_i & t_i;
      cpu_regs_pkg::OP_OR: result_o = byte_i ? {a_i[15:8], a_i[7:0] | t_i[7:0]} : a_i | t_i;
      cpu_regs_pkg::OP_XOR: result_o = byte_i ? {a_i[15:8], a_i[7:0] ^ t_i[7:0]} : a_i ^ t_i;
      default: result_o = byte_i ? {a_i[15:8], t_i[7:0]} : t_i;
    endcase
    msb_a = byte_i ? a_i[7] : a_i[15];
    msb_b = byte_i ? b[7] : b[15];
    msb_r = byte_i ? result_o[7] : result_o[15];
    flags_o.negative = msb_r;
    flags_o.zero = byte_i ? (result_o[7:0] == 8'h00) : (result_o == 16'h0000);
    // Logical, shift and move operations cannot overflow
    flags_o.overflow = (op_i <= cpu_regs_pkg::OP_SBC) && (msb_a == msb_b) && (msb_r != msb_a);
  end
endmodule // alu_flags

//--- hdl/addr_gen.sv
// Register-bank and direct-window address generation
`include "cpu_regs_map.svh"
module addr_gen (
  input wire logic [4:0] bank_select_i,
  input wire logic [2:0] direct_window_sel_i,
  input wire logic [2:0] opcode_lo_i,
  input wire logic [7:0] direct_i,
  output logic [15:0] gpr_addr_o,
  output logic [15:0] direct_addr_o
);
  function automatic logic [15:0] gpr_addr(input logic [4:0] bank, input logic [2:0] sel);
    gpr_addr = {`GPR_AREA_BIT, bank, sel};
  endfunction

  function automatic logic [15:0] direct_map(input logic [2:0] win, input logic [7:0] ofs);
    logic [3:0] blk;
    blk = {1'b0, win} + 4'h1;
    // Window 0 lands on 0080..00FF, so no special case is needed for it
    if (!ofs[7]) begin
      direct_map = {`PAGE_ZERO_HI, ofs};
    end else begin
      direct_map = {5'h00, blk, ofs[6:0]};
    end
  endfunction

  assign gpr_addr_o = gpr_addr(bank_select_i, opcode_lo_i);
  assign direct_addr_o = direct_map(direct_window_sel_i, direct_i);
endmodule // addr_gen

//--- verif/cpu_register_bank_chk.sv
// Port-level assertions for the CPU register bank
module cpu_register_bank_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic pc_inc_i,
  input wire logic pc_load_i,
  input wire logic [15:0] pc_value_i,
  input wire cpu_regs_pkg::addr_sel_t mem_sel_i,
  input wire logic [2:0] opcode_lo_i,
  input wire logic [7:0] direct_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic irq_req_i,
  input wire logic [1:0] irq_level_i,
  input wire logic irq_accept_o,
  input wire logic [15:0] program_counter_o,
  input wire logic [15:0] program_status_word_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic quiet;
  assign quiet = !pc_inc_i && !pc_load_i && !reg_wr_i;
  pc_load_a: assert property (pc_load_i && !pc_inc_i && !reg_wr_i |=>
    program_counter_o == $past(pc_value_i)) else $error("pc load value wrong");
  pc_step_a: assert property (pc_inc_i && !pc_load_i && !reg_wr_i |=>
    program_counter_o == $past(program_counter_o) + 16'h0001) else $error("pc step wrong");
  pc_hold_a: assert property (quiet |=> $stable(program_counter_o)) else $error("pc moved");
  fetch_addr_a: assert property (mem_sel_i == cpu_regs_pkg::SEL_FETCH && quiet |=>
    mem_addr_o == $past(program_counter_o)) else $error("fetch address wrong");
  irq_gate_a: assert property (irq_accept_o == $past(irq_req_i && program_status_word_o[6] &&
    (irq_level_i < program_status_word_o[5:4]))) else $error("interrupt gate wrong");
  gpr_addr_a: assert property (mem_sel_i == cpu_regs_pkg::SEL_GPR |=>
    mem_addr_o == {8'h01, $past(program_status_word_o[15:11]), $past(opcode_lo_i)})
    else $error("register address wrong");
  direct_low_a: assert property (mem_sel_i == cpu_regs_pkg::SEL_DIRECT && !direct_i[7] |=>
    mem_addr_o == {8'h00, $past(direct_i)}) else $error("low direct address moved");
  direct_win_a: assert property (mem_sel_i == cpu_regs_pkg::SEL_DIRECT && direct_i[7] |=>
    mem_addr_o == {5'b00000, $past(program_status_word_o[10:8]) + 4'h1, $past(direct_i[6:0])})
    else $error("direct window address wrong");
endmodule // cpu_register_bank_chk

bind cpu_register_bank cpu_register_bank_chk u_cpu_register_bank_chk (.clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
  .pc_inc_i, .pc_load_i, .pc_value_i, .mem_sel_i, .opcode_lo_i, .direct_i, .mem_addr_o, .irq_req_i,
  .irq_level_i, .irq_accept_o, .program_counter_o, .program_status_word_o);

//--- verif/irq_source.sv
// Interrupt request source on the far side of the register bank
module irq_source (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic want_i,
  input wire logic [1:0] level_want_i,
  output logic irq_req_o,
  output logic [1:0] irq_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle level keeps toggling so a stale value is never mistaken for a request level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_req_o <= 1'b0;
      irq_level_o <= 2'h0;
    end else begin
      irq_req_o <= want_i;
      irq_level_o <= want_i ? level_want_i : ~irq_level_o;
    end
  end
endmodule // irq_source

//--- verif/cpu_register_bank_test.sv
// Self-checking bench for the CPU register bank
module cpu_register_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    cpu_regs_pkg::alu_op_t op; logic byt; logic [15:0] a; logic [15:0] t; logic [15:0] r; logic [7:0] f;
  } alu_case_t;
  logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, alu_go_i = 1'b0, alu_byte_i = 1'b0;
  logic pc_inc_i = 1'b0, pc_load_i = 1'b0, sp_push_i = 1'b0, sp_pop_i = 1'b0, want = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000, pc_value_i = 16'h0000, got;
  logic [2:0] opcode_lo_i = 3'h0;
  logic [7:0] direct_i = 8'h00, index_disp_i = 8'h00;
  logic [1:0] want_lvl = 2'h0;
  cpu_regs_pkg::alu_op_t alu_op_i = cpu_regs_pkg::OP_ADD;
  cpu_regs_pkg::addr_sel_t mem_sel_i = cpu_regs_pkg::SEL_FETCH;
  logic [15:0] reg_rdata_o, mem_addr_o, program_counter_o, program_status_word_o;
  logic irq_req_i, irq_accept_o;
  logic [1:0] irq_level_i;
  int num_errors = 0, comparisons = 0, cycles = 0;
  alu_case_t cases [13] = '{
    '{cpu_regs_pkg::OP_ADC, 1'b1, 16'h00FF, 16'h0000, 16'h0000, 8'h85},
    '{cpu_regs_pkg::OP_SBC, 1'b0, 16'h0005, 16'h0003, 16'h0001, 8'h00},
    '{cpu_regs_pkg::OP_OR, 1'b1, 16'h12F0, 16'h000F, 16'h12FF, 8'h08},
    '{cpu_regs_pkg::OP_XOR, 1'b0, 16'hFFFF, 16'hFFFF, 16'h0000, 8'h04},
    '{cpu_regs_pkg::OP_PASS, 1'b0, 16'h1234, 16'h8001, 16'h8001, 8'h08},
    '{cpu_regs_pkg::OP_ADD, 1'b1, 16'hAB08, 16'h0008, 16'hAB10, 8'h80},
    '{cpu_regs_pkg::OP_ADD, 1'b1, 16'h00FF, 16'h0001, 16'h0000, 8'h85},
    '{cpu_regs_pkg::OP_ADD, 1'b1, 16'h007F, 16'h0001, 16'h0080, 8'h8A},
    '{cpu_regs_pkg::OP_SUB, 1'b0, 16'h0000, 16'h0001, 16'hFFFF, 8'h89},
    '{cpu_regs_pkg::OP_SUB, 1'b0, 16'h8000, 16'h0001, 16'h7FFF, 8'h82},
    '{cpu_regs_pkg::OP_SHL, 1'b1, 16'h00C0, 16'h0000, 16'h0080, 8'h09},
    '{cpu_regs_pkg::OP_SHR, 1'b1, 16'h0001, 16'h0000, 16'h0000, 8'h05},
    '{cpu_regs_pkg::OP_AND, 1'b0, 16'hF0F0, 16'h0F0F, 16'h0000, 8'h04}};
  // Status word, request level, expected acceptance
  logic [23:0] irq_cases [6] = '{24'h0070_2_1, 24'h0070_3_0, 24'h0030_0_0, 24'h0050_0_1, 24'h0050_1_0, 24'h0070_2_0};

  always #25 clk_i = ~clk_i;

  cpu_register_bank u_cpu_register_bank (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .alu_go_i, .alu_op_i, .alu_byte_i, .pc_inc_i, .pc_load_i, .pc_value_i, .sp_push_i, .sp_pop_i,
    .mem_sel_i, .opcode_lo_i, .direct_i, .index_disp_i, .mem_addr_o, .irq_req_i, .irq_level_i, .irq_accept_o,
    .program_counter_o, .program_status_word_o);
  irq_source u_irq_source (.clk_i, .rst_n_i, .want_i(want), .level_want_i(want_lvl), .irq_req_o(irq_req_i),
    .irq_level_o(irq_level_i));

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a; reg_wdata_i <= d; reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    reg_addr_i <= a; reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 got = reg_rdata_o;
  endtask
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin rd(4'(i)); chk(got, 16'h0000); end
    rd(4'hF); chk(got, 16'h0000);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin wr(4'(i), {4'(i), 4'h5, ~4'(i), 4'hA}); end
    wr(4'h7, 16'hFFFF);
    for (int i = 0; i < 8; i++) begin rd(4'(i)); chk(got, i == 7 ? 16'h0000 : {4'(i), 4'h5, ~4'(i), 4'hA}); end
    chk(program_status_word_o, 16'h659A);
  endtask
  task automatic t_alu();
    foreach (cases[i]) begin
      // Carry starts set for the operations that consume it
      wr(4'h6, {15'h0000, (cases[i].op == cpu_regs_pkg::OP_ADC || cases[i].op == cpu_regs_pkg::OP_SBC)});
      wr(4'h1, cases[i].a); wr(4'h2, cases[i].t);
      @(posedge clk_i);
      alu_op_i <= cases[i].op; alu_byte_i <= cases[i].byt; alu_go_i <= 1'b1;
      @(posedge clk_i);
      alu_go_i <= 1'b0;
      rd(4'h1); chk(got, cases[i].r);
      rd(4'h6); chk(got, {8'h00, cases[i].f});
    end
  endtask
  task automatic t_pc_sp();
    @(posedge clk_i); pc_load_i <= 1'b1; pc_value_i <= 16'h1234;
    @(posedge clk_i); pc_load_i <= 1'b0; pc_inc_i <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i); pc_inc_i <= 1'b0;
    @(posedge clk_i); #1 chk(program_counter_o, 16'h1236);
    chk(mem_addr_o, 16'h1236);
    wr(4'h5, 16'h0100);
    @(posedge clk_i); sp_push_i <= 1'b1;
    @(posedge clk_i); sp_push_i <= 1'b0;
    rd(4'h5); chk(got, 16'h00FE);
    @(posedge clk_i); sp_pop_i <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i); sp_push_i <= 1'b1;
    @(posedge clk_i); sp_push_i <= 1'b0; sp_pop_i <= 1'b0;
    rd(4'h5); chk(got, 16'h0102);
    @(posedge clk_i); mem_sel_i <= cpu_regs_pkg::SEL_INDEXED; index_disp_i <= 8'hF6;
    @(posedge clk_i); mem_sel_i <= cpu_regs_pkg::SEL_EXTRA;
    #1 chk(mem_addr_o, 16'h35C0);
    @(posedge clk_i); mem_sel_i <= cpu_regs_pkg::SEL_STACK;
    #1 chk(mem_addr_o, 16'h45BA);
    @(posedge clk_i); mem_sel_i <= cpu_regs_pkg::SEL_FETCH;
    #1 chk(mem_addr_o, 16'h0102);
  endtask
  task automatic t_addr();
    for (int i = 0; i < 8; i++) begin
      wr(4'h6, {i[2:0], 2'b10, i[2:0], 8'h00});
      @(posedge clk_i); mem_sel_i <= cpu_regs_pkg::SEL_DIRECT; direct_i <= 8'h85;
      @(posedge clk_i); #1 chk(mem_addr_o, 16'(16'h0080 * (i + 1) + 5));
      direct_i <= 8'h05;
      @(posedge clk_i); #1 chk(mem_addr_o, 16'h0005);
      mem_sel_i <= cpu_regs_pkg::SEL_GPR; opcode_lo_i <= ~i[2:0];
      @(posedge clk_i); #1 chk(mem_addr_o, {8'h01, i[2:0], 2'b10, ~i[2:0]});
      mem_sel_i <= cpu_regs_pkg::SEL_FETCH;
    end
  endtask
  task automatic t_irq();
    foreach (irq_cases[i]) begin
      wr(4'h6, irq_cases[i][23:8]);
      @(posedge clk_i); want <= irq_cases[i][0] | (i != 5); want_lvl <= irq_cases[i][5:4];
      repeat (3) @(posedge clk_i);
      #1 chk({15'h0000, irq_accept_o}, {15'h0000, irq_cases[i][0]});
      want <= 1'b0;
    end
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_regs();
    t_alu();
    t_pc_sp();
    t_addr();
    t_irq();
    print_verdict();
  end
endmodule // cpu_register_bank_test
